// ===== shared/sef_pkg.sv
// Purpose: Constants and carrier types for the servo enable and following-error block
// Assumes: One 50 MHz clock, step/dir/enable inputs already synchronous
// Notes: Functional notes follow
// Functional notes
// - Software enable mode, enable high: drive active, step and direction executed except on cycles where a step test moves the setpoint.
// - Software enable mode, enable low: steps ignored, output relay opened.
// - Always-enabled mode ignores enable input, drive stays active.
// - A held setting, loaded from the config link, picks the enable mode.
// - Deviation above limit raises tracking error output, fault indicator, motor off.
// - Following-error limit is a stored value 0 to 32767; above 10 only advised.
// - Tracking error stays latched until reset button or power removal.
// - Step test moves programmed count 1 to 32767; optional alternating direction.
// - Recorded step test captures programmed sample count 1 to 32767.
// - On request the present encoder position is returned.
// - Each step pulse advances setpoint by multiplier 1 to 50, default 1.
package sef_pkg;
    localparam int POS_W = 32;
    localparam logic [14:0] LIMIT_RST = 15'h7FFF;
    localparam logic [5:0] MULT_RST = 6'h01;
    localparam logic [5:0] MULT_MAX = 6'h32;
    localparam logic [14:0] COUNT_MIN = 15'h0001;
    localparam logic [15:0] SAMPLE_DIV = 16'h01F4;

    typedef struct packed {
        logic cfg_load;
        logic always_en;
        logic [14:0] err_limit;
        logic [5:0] step_mult;
        logic [14:0] test_steps;
        logic [14:0] test_samples;
        logic alt_dir;
    } sef_cfg_t;

    typedef struct packed {
        logic step;
        logic dir;
        logic enable;
    } sef_cmd_t;

    typedef enum logic [1:0] {
        SEF_IDLE,
        SEF_MOVE,
        SEF_DONE
    } sef_test_state_t;
endpackage

// ===== src/sef_abs_diff.sv
// Purpose: Absolute value of setpoint minus position
// Assumes: Signed two's complement positions
// Notes: Pure combinational
`timescale 1ns/100ps
module sef_abs_diff (
    input wire logic signed [sef_pkg::POS_W-1:0] a_in,
    input wire logic signed [sef_pkg::POS_W-1:0] b_in,
    output logic [sef_pkg::POS_W-1:0] mag_out
);
    logic signed [sef_pkg::POS_W-1:0] diff;
    always_comb begin
        diff = a_in - b_in;
        mag_out = diff[sef_pkg::POS_W-1] ? sef_pkg::POS_W'(-diff) : diff;
    end
endmodule

// ===== src/sef_top.sv
// Purpose: Enable gating, step setpoint, following-error latch, step test, capture
// Assumes: Config values arrive on ports with a load strobe from the config link
// Notes: Samples are taken every SAMPLE_DIV cycles during a recorded test
`timescale 1ns/100ps
module sef_top (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire sef_pkg::sef_cmd_t cmd_in,
    input wire sef_pkg::sef_cfg_t cfg_in,
    input wire logic signed [sef_pkg::POS_W-1:0] enc_pos_in,
    input wire logic test_start_in,
    input wire logic test_record_in,
    input wire logic pos_req_in,
    output logic active_out,
    output logic relay_closed_out,
    output logic track_err_out,
    output logic fault_indicator_out,
    output logic signed [sef_pkg::POS_W-1:0] setpoint_out,
    output logic signed [sef_pkg::POS_W-1:0] pos_data_out,
    output logic pos_valid_out,
    output logic signed [sef_pkg::POS_W-1:0] sample_data_out,
    output logic sample_valid_out,
    output logic test_busy_out
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic always_en;
        logic [14:0] err_limit;
        logic [5:0] step_mult;
        logic [14:0] test_steps;
        logic [14:0] test_samples;
        logic alt_dir;
        logic step_prev;
        logic active;
        logic track_err;
        logic signed [sef_pkg::POS_W-1:0] setpoint;
        logic signed [sef_pkg::POS_W-1:0] pos_data;
        logic pos_valid;
        logic signed [sef_pkg::POS_W-1:0] sample_data;
        logic sample_valid;
        sef_pkg::sef_test_state_t tstate;
        logic [14:0] steps_left;
        logic [14:0] samples_left;
        logic [15:0] div_cnt;
        logic recording;
        logic test_dir;
        logic busy;
    } sef_state_t;

    sef_state_t state_reg;
    sef_state_t state_next;
    logic [sef_pkg::POS_W-1:0] err_mag;

    sef_abs_diff u_abs (
        .a_in(state_reg.setpoint),
        .b_in(enc_pos_in),
        .mag_out(err_mag)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        state_next.pos_valid = 1'b0;
        state_next.sample_valid = 1'b0;
        state_next.step_prev = cmd_in.step;
        if (cfg_in.cfg_load) begin
            state_next.always_en = cfg_in.always_en;
            state_next.err_limit = cfg_in.err_limit;
            state_next.step_mult = (cfg_in.step_mult == 6'h00) ? sef_pkg::MULT_RST :
                ((cfg_in.step_mult > sef_pkg::MULT_MAX) ? sef_pkg::MULT_MAX : cfg_in.step_mult);
            state_next.test_steps = (cfg_in.test_steps == 15'h0000) ? sef_pkg::COUNT_MIN :
                cfg_in.test_steps;
            state_next.test_samples = (cfg_in.test_samples == 15'h0000) ? sef_pkg::COUNT_MIN :
                cfg_in.test_samples;
            state_next.alt_dir = cfg_in.alt_dir;
        end
        // Latched until reset; a new fault outranks the enable for the next active value
        if (err_mag > {17'h00000, state_reg.err_limit}) begin
            state_next.track_err = 1'b1;
        end
        state_next.active = (state_reg.always_en || cmd_in.enable) &&
            !state_next.track_err;
        if (state_reg.active && cmd_in.step && !state_reg.step_prev) begin
            if (cmd_in.dir) begin
                state_next.setpoint = state_reg.setpoint -
                    $signed({26'h0000000, state_reg.step_mult});
            end else begin
                state_next.setpoint = state_reg.setpoint +
                    $signed({26'h0000000, state_reg.step_mult});
            end
        end
        if (pos_req_in) begin
            state_next.pos_data = enc_pos_in;
            state_next.pos_valid = 1'b1;
        end
        case (state_reg.tstate)
            sef_pkg::SEF_IDLE: begin
                if (test_start_in && state_reg.active) begin
                    state_next.tstate = sef_pkg::SEF_MOVE;
                    state_next.steps_left = state_reg.test_steps;
                    state_next.samples_left = state_reg.test_samples;
                    state_next.recording = test_record_in;
                    state_next.div_cnt = 16'h0000;
                end
            end
            sef_pkg::SEF_MOVE: begin
                if (!state_reg.active) begin
                    state_next.tstate = sef_pkg::SEF_DONE;
                end else begin
                    if (state_reg.steps_left != 15'h0000) begin
                        state_next.steps_left = state_reg.steps_left - 15'h0001;
                        state_next.setpoint = state_reg.test_dir ?
                            state_reg.setpoint - 32'sh00000001 : state_reg.setpoint + 32'sh00000001;
                    end
                    if (state_reg.recording && state_reg.samples_left != 15'h0000) begin
                        if (state_reg.div_cnt == 16'h0000) begin
                            state_next.sample_data = enc_pos_in;
                            state_next.sample_valid = 1'b1;
                            state_next.samples_left = state_reg.samples_left - 15'h0001;
                            state_next.div_cnt = sef_pkg::SAMPLE_DIV - 16'h0001;
                        end else begin
                            state_next.div_cnt = state_reg.div_cnt - 16'h0001;
                        end
                    end
                    if (state_reg.steps_left == 15'h0000 &&
                        (!state_reg.recording || state_reg.samples_left == 15'h0000)) begin
                        state_next.tstate = sef_pkg::SEF_DONE;
                    end
                end
            end
            sef_pkg::SEF_DONE: begin
                if (state_reg.alt_dir) begin
                    state_next.test_dir = !state_reg.test_dir;
                end
                state_next.tstate = sef_pkg::SEF_IDLE;
            end
            default: begin
                state_next.tstate = sef_pkg::SEF_IDLE;
            end
        endcase
        // Busy is registered so the output comes straight from a flip-flop
        state_next.busy = (state_next.tstate != sef_pkg::SEF_IDLE);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= '0;
            state_reg.err_limit <= sef_pkg::LIMIT_RST;
            state_reg.step_mult <= sef_pkg::MULT_RST;
            state_reg.test_steps <= sef_pkg::COUNT_MIN;
            state_reg.test_samples <= sef_pkg::COUNT_MIN;
            state_reg.tstate <= sef_pkg::SEF_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active_out = state_reg.active;
    assign relay_closed_out = state_reg.active;
    assign track_err_out = state_reg.track_err;
    assign fault_indicator_out = state_reg.track_err;
    assign setpoint_out = state_reg.setpoint;
    assign pos_data_out = state_reg.pos_data;
    assign pos_valid_out = state_reg.pos_valid;
    assign sample_data_out = state_reg.sample_data;
    assign sample_valid_out = state_reg.sample_valid;
    assign test_busy_out = state_reg.busy;
endmodule

// ===== tb/sef_chk.sv
// Purpose: Checker for sef_top
// Assumes: Bound to sef_top
// Notes: Mirrors the held config
`timescale 1ns/100ps
module sef_chk (
    input wire logic core_clk_in, rst_in, pos_req_in,
    input wire sef_pkg::sef_cmd_t cmd_in,
    input wire sef_pkg::sef_cfg_t cfg_in,
    input wire logic signed [31:0] enc_pos_in, setpoint_out, pos_data_out,
    input wire logic active_out, relay_closed_out, track_err_out,
    input wire logic fault_indicator_out, pos_valid_out, test_busy_out
);
    logic ae_reg;
    logic [14:0] lim_reg;
    logic [5:0] mul_reg;
    logic [32:0] mag;
    wire signed [32:0] dif = setpoint_out - enc_pos_in;
    assign mag = dif[32] ? -dif : dif;
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ae_reg <= 1'b0;
            lim_reg <= 15'h7FFF;
            mul_reg <= 6'h01;
        end else if (cfg_in.cfg_load) begin
            ae_reg <= cfg_in.always_en;
            lim_reg <= cfg_in.err_limit;
            mul_reg <= (cfg_in.step_mult > 6'h32) ? 6'h32
                : (cfg_in.step_mult | {5'h00, ~|cfg_in.step_mult});
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_set; mag > {18'h00000, lim_reg} |=> track_err_out; endproperty
    a_set: assert property (p_set) else $error("fault not raised");
    property p_hold_err; track_err_out |=> track_err_out; endproperty
    a_hold_err: assert property (p_hold_err) else $error("fault cleared");
    property p_off; track_err_out |-> !active_out && fault_indicator_out; endproperty
    a_off: assert property (p_off) else $error("fault not shown");
    property p_relay; relay_closed_out == active_out; endproperty
    a_relay: assert property (p_relay) else $error("relay wrong");
    property p_sw; !ae_reg && !cmd_in.enable |=> !active_out; endproperty
    a_sw: assert property (p_sw) else $error("active while low");
    property p_on; (ae_reg || cmd_in.enable) ##1 !track_err_out |-> active_out; endproperty
    a_on: assert property (p_on) else $error("not active");
    property p_step; !test_busy_out && active_out && cmd_in.step && !$past(cmd_in.step)
        |=> setpoint_out == ($past(cmd_in.dir) ? $past(setpoint_out) - $past(mul_reg)
        : $past(setpoint_out) + $past(mul_reg)); endproperty
    a_step: assert property (p_step) else $error("bad step");
    property p_still; !active_out && !test_busy_out |=> $stable(setpoint_out); endproperty
    a_still: assert property (p_still) else $error("moved inactive");
    property p_pos; pos_req_in |=> pos_valid_out && pos_data_out == $past(enc_pos_in);
    endproperty
    a_pos: assert property (p_pos) else $error("bad position");
    c_fault: cover property (track_err_out);
    c_test: cover property (test_busy_out);
    c_pos: cover property (pos_valid_out);
endmodule
bind sef_top sef_chk u_chk (.*);

// ===== tb/sef_ctl_model.sv
// Purpose: Step/direction controller model
// Assumes: Inputs change at falling edge
// Notes: Pulse hold sets the step rate
`timescale 1ns/100ps
module sef_ctl_model (
    input wire logic clk_in,
    output sef_pkg::sef_cmd_t cmd_out
);
    initial cmd_out = 3'h0;
    task automatic pulse(input logic dir, input int hold);
        @(negedge clk_in);
        cmd_out.dir = dir;
        cmd_out.step = 1'b1;
        repeat (hold) @(negedge clk_in);
        cmd_out.step = 1'b0;
        repeat (hold) @(negedge clk_in);
    endtask
    task automatic set_en(input logic en);
        @(negedge clk_in);
        cmd_out.enable = en;
    endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: Bench for sef_top
// Assumes: Inputs driven at falling edge
// Notes: Steps 5 and samples 1 per test
`timescale 1ns/100ps
module tb_top;
    logic clk, rst, start, rec, preq, act, rly, terr, find, pv, sv, busy;
    sef_pkg::sef_cmd_t cmd;
    sef_pkg::sef_cfg_t cfg;
    logic signed [31:0] enc, sp, pd, sd;
    int mismatches, total_checks, cycles, nsv;
    sef_top DUT (.core_clk_in(clk), .rst_in(rst), .cmd_in(cmd), .cfg_in(cfg),
        .enc_pos_in(enc), .test_start_in(start), .test_record_in(rec), .pos_req_in(preq),
        .active_out(act), .relay_closed_out(rly), .track_err_out(terr),
        .fault_indicator_out(find), .setpoint_out(sp), .pos_data_out(pd), .pos_valid_out(pv),
        .sample_data_out(sd), .sample_valid_out(sv), .test_busy_out(busy));
    sef_ctl_model ctl (.clk_in(clk), .cmd_out(cmd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cfgw(input logic ae, input logic [14:0] lim, input logic [5:0] m);
        @(negedge clk);
        cfg = '{1'b1, ae, lim, m, 15'h0005, 15'h0001, 1'b1};
        @(negedge clk);
        cfg.cfg_load = 1'b0;
    endtask
    task automatic run_test(input logic r);
        @(negedge clk);
        start = 1'b1;
        rec = r;
        @(negedge clk);
        start = 1'b0;
        for (int i = 0; i < 50 && busy !== 1'b0; i++) @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) begin
        cycles++;
        if (sv === 1'b1) nsv++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        rst = 1'b1;
        start = 1'b0;
        rec = 1'b0;
        preq = 1'b0;
        cfg = '0;
        enc = 32'h00000000;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        cfgw(1'b0, 15'h7FFF, 6'h3F);
        ctl.set_en(1'b1);
        ctl.pulse(1'b0, 1);
        chk(sp, 32'h00000032);
        ctl.pulse(1'b1, 1);
        chk(sp, 32'h00000000);
        cfgw(1'b0, 15'h7FFF, 6'h00);
        ctl.pulse(1'b1, 1);
        chk(sp, 32'hFFFFFFFF);
        $display("test 1 done");
        ctl.set_en(1'b0);
        ctl.pulse(1'b0, 2);
        chk(sp, 32'hFFFFFFFF);
        chk({act, rly}, 32'h00000000);
        cfgw(1'b1, 15'h7FFF, 6'h01);
        ctl.pulse(1'b0, 1);
        chk(sp, 32'h00000000);
        chk(32'(act), 32'h00000001);
        $display("test 2 done");
        enc = 32'h00000100;
        run_test(1'b1);
        chk(sp, 32'h00000005);
        chk(32'(nsv), 32'h00000001);
        chk(sd, 32'h00000100);
        run_test(1'b0);
        chk(sp, 32'h00000000);
        $display("test 3 done");
        cfgw(1'b1, 15'h000A, 6'h01);
        enc = 32'hFFFFFFF6;
        repeat (2) @(negedge clk);
        chk(32'(terr), 32'h00000000);
        enc = 32'h0000000B;
        @(negedge clk);
        chk({terr, find, act}, 32'h00000006);
        enc = 32'h1234ABCD;
        preq = 1'b1;
        @(negedge clk);
        preq = 1'b0;
        chk(pd, 32'h1234ABCD);
        chk(32'(pv), 32'h00000001);
        ctl.pulse(1'b0, 1);
        chk({sp[30:0], terr}, 32'h00000001);
        rst = 1'b1;
        enc = 32'h00000000;
        @(negedge clk);
        rst = 1'b0;
        chk(32'(terr), 32'h00000000);
        $display("test 4 done");
        conclude();
    end
endmodule
